// ==== lin_slave_baud.sv ====
// LIN slave baud-rate generation, break search and synch field auto-resynchronization
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "lin_params.svh"

module lin_slave_baud (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  input  wire logic       rx_serial_in_i,
  output logic      [7:0] rdata_o,
  output logic            baud_tick_o,
  output logic            rx_full_o,
  output logic            sync_state_o
);

  // register state
  lin_pkg::ctrl_s         ctrl;
  lin_pkg::ctrl_s         next_ctrl;
  logic            [11:0] nominal_divider;
  logic            [11:0] measured_divider;
  logic            [11:0] active_baud_divider;
  logic            [11:0] next_active;
  logic             [7:0] master_prescale;
  logic             [7:0] rx_data;
  logic                   header_flag;

  // receive input conditioning
  logic                   rx_s1;
  logic                   rx_s2;
  logic                   rx_s3;
  logic                   rx_bit;
  logic                   rx_prev;

  // receiver
  lin_pkg::rx_state_e     state;
  logic             [3:0] sample_cnt;
  logic             [1:0] votes;
  logic             [3:0] bit_idx;
  logic             [7:0] shift_reg;
  logic                   char_done;

  // break and synch field
  logic             [7:0] low_ticks;
  logic                   sync_active;
  logic             [2:0] edge_cnt;
  logic            [14:0] sync_measure_count;
  logic                   in_header;
  logic             [1:0] chars_seen;

  wire                    tick;
  wire                    slave_mode;
  wire                    auto_sync_on;
  wire             [11:0] gen_div;
  wire                    rx_fall;
  wire                    rx_rise;
  wire                    halt;
  wire                    resync;
  wire                    samp_vote;
  wire                    samp_mid;
  wire                    samp_end;
  wire              [1:0] vote_sum;
  wire                    vote_bit;
  wire                    stop_ok;
  wire                    brk_evt;
  wire                    meas_done;
  wire                    meas_ovf;
  wire             [11:0] meas_val;
  wire                    id_evt;
  wire                    header_evt;
  wire                    wake_evt;
  wire                    suppress;
  wire                    data_load;
  wire                    pending_load;

  // bus decode
  wire                    wr_int;
  wire                    wr_frac;
  wire                    wr_ctrl;
  wire                    wr_master;
  wire                    rd_status;
  wire                    rd_data;
  wire              [7:0] status_byte;
  wire              [7:0] read_mux;

  assign wr_int    = wr_i & (addr_i == `ADDR_DIV_INT);
  assign wr_frac   = wr_i & (addr_i == `ADDR_DIV_FRAC);
  assign wr_ctrl   = wr_i & (addr_i == `ADDR_CTRL);
  assign wr_master = wr_i & (addr_i == `ADDR_MASTER_PRE);
  assign rd_status = rd_i & (addr_i == `ADDR_STATUS);
  assign rd_data   = rd_i & (addr_i == `ADDR_DATA);

  assign status_byte = {5'h00, rx_full_o, header_flag, sync_active};

  // divider registers read back the active divider
  assign read_mux =
    (addr_i == `ADDR_DIV_INT)    ? active_baud_divider[11:4] :         // R4
    (addr_i == `ADDR_DIV_FRAC)   ? {4'h0, active_baud_divider[3:0]} :  // R8
    (addr_i == `ADDR_CTRL)       ? {2'h0, ctrl} :
    (addr_i == `ADDR_STATUS)     ? status_byte :
    (addr_i == `ADDR_DATA)       ? rx_data :
    (addr_i == `ADDR_MASTER_PRE) ? master_prescale :
                                   8'h00;

  // mode decode
  assign slave_mode   = ctrl.lin_enable & ctrl.slave_select;  // R21
  assign auto_sync_on = slave_mode & ctrl.auto_sync_enable;   // R22

  // slave mode: one generator for both directions, master uses the prescaler
  assign gen_div = slave_mode ? active_baud_divider : {master_prescale, 4'h0};  // R6 R7

  baud_gen u_baud_gen (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .div_i     (gen_div),
    .resync_i  (resync),
    .tick_o    (tick)
  );

  assign baud_tick_o = tick;

  // edges seen on the CPU clock after filtering
  assign rx_fall = rx_prev & ~rx_bit;  // R16
  assign rx_rise = ~rx_prev & rx_bit;

  // receiver sampling points
  assign halt      = sync_active | brk_evt;  // R5
  assign resync    = (state == lin_pkg::RX_IDLE) & rx_fall & ~halt;  // R15
  assign samp_vote = tick & (sample_cnt >= `SAMPLE_FIRST) & (sample_cnt < `SAMPLE_LAST);
  assign samp_mid  = tick & (sample_cnt == `SAMPLE_LAST);
  assign samp_end  = tick & (sample_cnt == `SAMPLE_END);
  assign vote_sum  = votes + {1'b0, rx_bit};
  assign vote_bit  = vote_sum >= 2'h2;  // R14
  assign stop_ok   = (state == lin_pkg::RX_STOP) & samp_mid & vote_bit & ~halt;

  // break: return to recessive after at least 11 low bit times
  assign brk_evt = slave_mode & rx_rise & (low_ticks == `BREAK_TICKS);  // R11 R13 R18

  // synch field measurement result
  assign meas_done = sync_active & rx_fall & (edge_cnt == `SYNC_EDGE_LAST);  // R3
  assign meas_ovf  = sync_active & (edge_cnt != 3'h0) & (sync_measure_count == `SYNC_CNT_MAX);
  assign meas_val  = sync_measure_count[14:3];  // R23

  // header progress
  assign id_evt     = char_done & in_header & (chars_seen == 2'h1);
  assign header_evt = slave_mode & (ctrl.header_detect_method ? id_evt : brk_evt);
  assign wake_evt   = ctrl.rx_mute & header_evt;  // R17

  // muted receivers and identifier-method headers keep characters out, except the identifier that ends an identifier-method header
  assign suppress =
    (ctrl.rx_mute & ~(ctrl.header_detect_method & id_evt)) |         // R18
    (slave_mode & ctrl.header_detect_method & in_header & ~id_evt);
  assign data_load = char_done & ~suppress;

  assign pending_load = data_load & slave_mode & ctrl.update_method;

  // active divider: measurement, deferred load, then software with top priority
  always_comb
  begin
    next_active = active_baud_divider;
    if (meas_done)
    begin
      next_active = meas_val;  // R4 R1
    end
    if (pending_load)
    begin
      next_active = nominal_divider;  // R20
    end
    if (wr_int & ~ctrl.update_method)
    begin
      next_active = {wdata_i, nominal_divider[3:0]};  // R19 R10 R1
    end
  end

  // control: hardware clears, then a software write that overrides them, except rx_mute while slave_mode and rx_full_o are set
  always_comb
  begin
    next_ctrl = ctrl;
    if (pending_load)
    begin
      next_ctrl.update_method = 1'b0;  // R20
    end
    if (wake_evt)
    begin
      next_ctrl.rx_mute = 1'b0;  // R17
    end
    if (wr_ctrl)
    begin
      next_ctrl = lin_pkg::ctrl_s'(wdata_i[5:0]);
      if (slave_mode & rx_full_o)
      begin
        next_ctrl.rx_mute = ctrl.rx_mute;
      end
    end
  end

  // registers
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl                <= lin_pkg::ctrl_s'(`RST_CTRL);
      nominal_divider     <= {`RST_DIV_INT, `RST_DIV_FRAC};
      active_baud_divider <= {`RST_DIV_INT, `RST_DIV_FRAC};
      master_prescale     <= `RST_MASTER_PRE;
    end
    else
    begin
      ctrl                <= next_ctrl;
      active_baud_divider <= next_active;
      if (wr_int)
      begin
        nominal_divider[11:4] <= wdata_i;  // R9
      end
      if (wr_frac)
      begin
        nominal_divider[3:0] <= wdata_i[3:0];  // R8
      end
      if (wr_master)
      begin
        master_prescale <= wdata_i;
      end
    end
  end

  // flags: a same-cycle set wins over the read that clears
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      header_flag <= 1'b0;
      rx_full_o   <= 1'b0;
      rx_data     <= 8'h00;
      rdata_o     <= 8'h00;
    end
    else
    begin
      header_flag <= header_evt | (header_flag & ~rd_status);
      rx_full_o   <= data_load | (rx_full_o & ~rd_data);
      if (data_load)
      begin
        rx_data <= shift_reg;
      end
      rdata_o <= rd_i ? read_mux : 8'h00;
    end
  end

  // three-stage input; level accepted once stages two and three agree
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_s1   <= 1'b1;
      rx_s2   <= 1'b1;
      rx_s3   <= 1'b1;
      rx_bit  <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_s1   <= rx_serial_in_i;
      rx_s2   <= rx_s1;
      rx_s3   <= rx_s2;
      rx_prev <= rx_bit;
      if (rx_s2 == rx_s3)
      begin
        rx_bit <= rx_s3;
      end
    end
  end

  // character receiver, halted while the synch field is measured
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state      <= lin_pkg::RX_IDLE;
      sample_cnt <= 4'h0;
      votes      <= 2'h0;
      bit_idx    <= 4'h0;
      shift_reg  <= 8'h00;
      char_done  <= 1'b0;
    end
    else
    begin
      char_done <= stop_ok;
      if (halt)
      begin
        state <= lin_pkg::RX_IDLE;  // R5
      end
      else
      begin
        unique case (state)
          lin_pkg::RX_IDLE:
          begin
            if (rx_fall)
            begin
              state      <= lin_pkg::RX_START;
              sample_cnt <= 4'h0;  // R15
              votes      <= 2'h0;
              bit_idx    <= 4'h0;
            end
          end
          lin_pkg::RX_START, lin_pkg::RX_DATA, lin_pkg::RX_STOP:
          begin
            if (tick)
            begin
              sample_cnt <= sample_cnt + 4'h1;
            end
            if (samp_vote)
            begin
              votes <= vote_sum;  // R14
            end
            if (samp_mid)
            begin
              votes <= 2'h0;
              if (state == lin_pkg::RX_START)
              begin
                if (vote_bit)
                begin
                  state <= lin_pkg::RX_IDLE;
                end
              end
              else if (state == lin_pkg::RX_DATA)
              begin
                shift_reg <= {vote_bit, shift_reg[7:1]};
                bit_idx   <= bit_idx + 4'h1;
              end
              else
              begin
                // stop bit done; a dominant stop is dropped as a framing error
                state <= lin_pkg::RX_IDLE;
              end
            end
            if (samp_end & (state != lin_pkg::RX_STOP))
            begin
              state <= (bit_idx == `DATA_BITS) ? lin_pkg::RX_STOP : lin_pkg::RX_DATA;
            end
          end
        endcase
      end
    end
  end

  // dominant length in oversampling ticks, saturating at the break length
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      low_ticks <= 8'h00;
    end
    else if (rx_bit)
    begin
      low_ticks <= 8'h00;
    end
    else if (tick & (low_ticks != `BREAK_TICKS))
    begin
      low_ticks <= low_ticks + 8'h01;  // R11
    end
  end

  // synch field measurement from first to fifth falling edge
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync_active        <= 1'b0;
      edge_cnt           <= 3'h0;
      sync_measure_count <= 15'h0000;
      measured_divider   <= 12'h000;
    end
    else if (brk_evt & auto_sync_on)
    begin
      sync_active        <= 1'b1;  // R3
      edge_cnt           <= 3'h0;
      sync_measure_count <= 15'h0000;
    end
    else if (~auto_sync_on | meas_ovf)
    begin
      sync_active <= 1'b0;
    end
    else if (sync_active)
    begin
      // the first edge counts too, so the total spans the whole eight bit times
      if ((edge_cnt != 3'h0) | rx_fall)
      begin
        sync_measure_count <= sync_measure_count + 15'h0001;  // R16
      end
      if (rx_fall)
      begin
        edge_cnt <= edge_cnt + 3'h1;
      end
      if (meas_done)
      begin
        sync_active      <= 1'b0;
        measured_divider <= meas_val;  // R9 R4
      end
    end
  end

  assign sync_state_o = sync_active;

  // character position since the last break
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      in_header  <= 1'b0;
      chars_seen <= 2'h0;
    end
    else if (brk_evt)
    begin
      in_header  <= 1'b1;
      chars_seen <= 2'h0;
    end
    else if (meas_done)
    begin
      chars_seen <= 2'h1;
    end
    else if (char_done & in_header)
    begin
      chars_seen <= chars_seen + 2'h1;
      if (chars_seen == 2'h1)
      begin
        in_header <= 1'b0;
      end
    end
  end

endmodule // lin_slave_baud

// ==== lin_params.svh ====
// constants for the LIN slave baud-rate and auto-sync block
// Notes on behaviour
// R1 - Baud rate comes from the software divider or from bus auto-resynchronization.
// R2 - Software loads the nominal divider first, then sets auto-sync enable.
// R3 - After each break, count CPU cycles over five falling edges in 15 bits.
// R4 - At the fifth falling edge load measurement into active and readable divider.
// R5 - During sync measurement the receiver is halted and writes no data.
// R6 - Master mode uses the conventional prescaler; slave divider only in slave mode.
// R7 - Slave mode: transmit and receive share one rate, CPU clock over 16 times divider.
// R8 - Divider is fixed point: 8-bit integer register, 4-bit fraction register.
// R9 - Three divider copies: nominal, measured and active.
// R10 - Software integer write beats a same-cycle measurement transfer into active divider.
// R11 - Slave: low for at least 11 bit times is a break, shorter is not.
// R12 - Bus master sends each break as 13 low bit times.
// R13 - Break detection still works with local clock off by fifteen percent.
// R14 - Each bit sampled 16 times; value voted from samples eight, nine, ten.
// R15 - Oversampling phase realigns on every start bit.
// R16 - Measurement spans eight bit times, counted and edge-detected on CPU clock.
// R17 - Muted slave wakes on break or identifier, chosen by header detect method.
// R18 - Slave mute discards bits and waits for 11 dominant bits.
// R19 - Update method clear: integer write updates active divider at once.
// R20 - Update method set: active updated at next received character, bit then cleared.
// R21 - Enable 0 disables LIN; enable 1 with slave select picks master or slave.
// R22 - Auto-sync enable acts only in LIN slave mode.
// R23 - Measured divider is eight-bit-time count divided by 128, four fraction bits.
`ifndef LIN_PARAMS_SVH
`define LIN_PARAMS_SVH

`define ADDR_DIV_INT      3'h0
`define ADDR_DIV_FRAC     3'h1
`define ADDR_CTRL         3'h2
`define ADDR_STATUS       3'h3
`define ADDR_DATA         3'h4
`define ADDR_MASTER_PRE   3'h5

`define RST_DIV_INT       8'h01
`define RST_DIV_FRAC      4'h0
`define RST_MASTER_PRE    8'h01
`define RST_CTRL          6'h00

`define STAT_SYNC_BIT     0
`define STAT_HEADER_BIT   1
`define STAT_FULL_BIT     2

`define OVERSAMPLE        13'h0010
`define DIV_MIN           12'h010
`define SAMPLE_FIRST      4'h7
`define SAMPLE_LAST       4'h9
`define SAMPLE_END        4'hF
`define DATA_BITS         4'h8
`define BREAK_TICKS       8'hB0
`define SYNC_EDGE_LAST    3'h4
`define SYNC_CNT_MAX      15'h7FFF

`endif

// ==== lin_pkg.sv ====
// types shared by the LIN slave baud-rate block
package lin_pkg;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } rx_state_e;

  typedef struct packed {
    logic update_method;
    logic lin_enable;
    logic slave_select;
    logic auto_sync_enable;
    logic header_detect_method;
    logic rx_mute;
  } ctrl_s;

endpackage

// ==== baud_gen.sv ====
// fractional 16x oversampling tick generator
`timescale 1ns/10ps
`include "lin_params.svh"

module baud_gen (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [11:0] div_i,
  input  wire logic        resync_i,
  output logic             tick_o
);

  logic [11:0] acc;
  wire  [11:0] div_eff;
  wire  [12:0] sum;
  wire  [12:0] diff;
  wire         hit;

  // divider below one would need more than one tick per cycle
  assign div_eff = (div_i < `DIV_MIN) ? `DIV_MIN : div_i;
  // 1/16 fixed point: a tick every div/16 cycles, sixteen per bit
  assign sum     = {1'b0, acc} + `OVERSAMPLE;
  assign hit     = sum >= {1'b0, div_eff};
  assign diff    = sum - {1'b0, div_eff};

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc    <= 12'h000;
      tick_o <= 1'b0;
    end
    else if (resync_i)
    begin
      acc    <= 12'h000;
      tick_o <= 1'b0;
    end
    else
    begin
      acc    <= hit ? diff[11:0] : sum[11:0];
      tick_o <= hit;
    end
  end

endmodule // baud_gen

// ==== lin_slave_baud_props.sv ====
// concurrent checks on the ports of the LIN slave baud block
`timescale 1ns/10ps
`include "lin_params.svh"

module lin_slave_baud_props (
  input wire logic       ref_clk_i,
  input wire logic       rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic       wr_i,
  input wire logic       rd_i,
  input wire logic       rx_serial_in_i,
  input wire logic [7:0] rdata_o,
  input wire logic       baud_tick_o,
  input wire logic       rx_full_o,
  input wire logic       sync_state_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic       update_method_shadow;
  logic [8:0] low_run;
  logic [8:0] last_run;

  // last software choice of update method; hardware clears are ignored (conservative)
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
      update_method_shadow <= 1'b0;
    else if (wr_i && addr_i == `ADDR_CTRL)
      update_method_shadow <= wdata_i[5];

  // length of the most recent low period on the line
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i)
    begin
      low_run  <= 9'h000;
      last_run <= 9'h000;
    end
    else
    begin
      low_run <= rx_serial_in_i ? 9'h000 : (low_run == 9'h1FF ? low_run : low_run + 9'h001);
      if (rx_serial_in_i && low_run != 9'h000)
        last_run <= low_run;
    end

  sequence int_wr_rd;
    wr_i && addr_i == `ADDR_DIV_INT && !update_method_shadow ##1
    rd_i && addr_i == `ADDR_DIV_INT && !sync_state_o;
  endsequence

  sequence sync_start;
    $rose(sync_state_o);
  endsequence

  chk_int_write: assert property (int_wr_rd |=> rdata_o == $past(wdata_i, 2))
    else $error("integer divider write not seen on readback");
  chk_frac_upper: assert property (rd_i && addr_i == `ADDR_DIV_FRAC |=> rdata_o[7:4] == 4'h0)
    else $error("fraction divider read has upper bits set");
  chk_no_full_sync: assert property (sync_state_o |=> !$rose(rx_full_o))
    else $error("character loaded during synch measurement");
  chk_sync_span: assert property (sync_start |-> sync_state_o [*8])
    else $error("synch measurement ended too early");
  chk_break_min: assert property (sync_start |-> last_run >= 9'h0B0)
    else $error("break accepted after too short a low period");
  chk_status_bits: assert property (rd_i && addr_i == `ADDR_STATUS
    |=> rdata_o[0] == $past(sync_state_o) && rdata_o[2] == $past(rx_full_o))
    else $error("status bits disagree with outputs");
  chk_unmapped_zero: assert property (rd_i && addr_i > `ADDR_MASTER_PRE |=> rdata_o == 8'h00)
    else $error("unmapped read returned data");
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data present without a read");
endmodule // lin_slave_baud_props

bind lin_slave_baud lin_slave_baud_props u_props (
  .ref_clk_i      (ref_clk_i),
  .rst_i          (rst_i),
  .addr_i         (addr_i),
  .wdata_i        (wdata_i),
  .wr_i           (wr_i),
  .rd_i           (rd_i),
  .rx_serial_in_i (rx_serial_in_i),
  .rdata_o        (rdata_o),
  .baud_tick_o    (baud_tick_o),
  .rx_full_o      (rx_full_o),
  .sync_state_o   (sync_state_o)
);

// ==== lin_master_model.sv ====
// behavioural LIN master node driving the receive line
`timescale 1ns/10ps

module lin_master_model (
  input  wire logic ref_clk_i,
  output logic      bus_o
);
  // recessive when idle, the bus is pulled up
  initial bus_o = 1'b1;

  task automatic hold_level(input logic lvl, input int cycles);
    bus_o <= lvl;
    repeat (cycles) @(negedge ref_clk_i);
  endtask

  task automatic send_break(input int bit_cyc);
    @(negedge ref_clk_i);
    hold_level(1'b0, 13 * bit_cyc);
    hold_level(1'b1, bit_cyc);
    @(posedge ref_clk_i);
  endtask

  task automatic send_byte(input logic [7:0] data, input int bit_cyc);
    int i;
    @(negedge ref_clk_i);
    hold_level(1'b0, bit_cyc);
    for (i = 0; i < 8; i++)
      hold_level(data[i], bit_cyc);
    hold_level(1'b1, 2 * bit_cyc);
    @(posedge ref_clk_i);
  endtask
endmodule // lin_master_model

// ==== tb.sv ====
// self-checking testbench for the LIN slave baud block
`timescale 1ns/10ps
`include "lin_params.svh"

`define CHK(name, exp, got) \
  begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error %s expected %h seen %h", name, exp, got); end end

module tb;
  logic       ref_clk_i;
  logic       rst_i;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic       wr_i;
  logic       rd_i;
  logic       rx_line;
  logic [7:0] rdata_o;
  logic       baud_tick_o;
  logic       rx_full_o;
  logic       sync_state_o;
  logic [7:0] rv;
  bit         saw_sync;
  int         mismatches;
  int         num_checks;
  int         n;

  lin_slave_baud dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rx_serial_in_i(rx_line), .rdata_o(rdata_o),
    .baud_tick_o(baud_tick_o), .rx_full_o(rx_full_o), .sync_state_o(sync_state_o));

  lin_master_model master (.ref_clk_i(ref_clk_i), .bus_o(rx_line));

  initial ref_clk_i = 1'b0;
  always #20 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i)
    if (sync_state_o === 1'b1)
      saw_sync = 1'b1;

  task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    @(posedge ref_clk_i);
  endtask

  task automatic check_reg(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    read_reg(a, d);
    `CHK("register", exp, d)
  endtask

  task automatic count_ticks(input int cycles, output int cnt);
    cnt = 0;
    repeat (cycles)
    begin
      @(posedge ref_clk_i);
      #1;
      if (baud_tick_o === 1'b1)
        cnt++;
    end
    @(posedge ref_clk_i);
  endtask

  task automatic t_reset_values();
    check_reg(`ADDR_DIV_INT, 8'h01);
    check_reg(`ADDR_DIV_FRAC, 8'h00);
    check_reg(`ADDR_CTRL, 8'h00);
    check_reg(3'h6, 8'h00);
    check_reg(3'h7, 8'h00);
  endtask

  task automatic t_div_write();
    write_reg(`ADDR_CTRL, 8'h18);
    write_reg(`ADDR_DIV_FRAC, 8'h03);
    check_reg(`ADDR_DIV_FRAC, 8'h00);
    write_reg(`ADDR_DIV_INT, 8'h05);
    check_reg(`ADDR_DIV_FRAC, 8'h03);
    write_reg(`ADDR_DIV_FRAC, 8'h00);
    write_reg(`ADDR_DIV_INT, 8'h05);
    check_reg(`ADDR_DIV_INT, 8'h05);
    count_ticks(20, n);
    count_ticks(400, n);
    `CHK("slave ticks", 80, n)
  endtask

  task automatic t_master_rate();
    logic [7:0] modes [2];
    modes = '{8'h10, 8'h00};
    write_reg(`ADDR_MASTER_PRE, 8'h03);
    foreach (modes[i])
    begin
      write_reg(`ADDR_CTRL, modes[i]);
      count_ticks(20, n);
      count_ticks(300, n);
      `CHK("prescaler ticks", 100, n)
    end
  endtask

  task automatic t_zero_char();
    write_reg(`ADDR_CTRL, 8'h1C);
    write_reg(`ADDR_DIV_INT, 8'h0A);
    saw_sync = 1'b0;
    master.send_byte(8'h00, 160);
    `CHK("full flag", 1'b1, rx_full_o)
    check_reg(`ADDR_DATA, 8'h00);
    master.send_byte(8'hA5, 160);
    check_reg(`ADDR_DATA, 8'hA5);
    `CHK("break on zero", 1'b0, saw_sync)
  endtask

  task automatic t_auto_sync();
    write_reg(`ADDR_CTRL, 8'h18);
    write_reg(`ADDR_DIV_INT, 8'h0B);
    write_reg(`ADDR_CTRL, 8'h1C);
    saw_sync = 1'b0;
    master.send_break(160);
    master.send_byte(8'h55, 160);
    `CHK("sync seen", 1'b1, saw_sync)
    `CHK("full after sync", 1'b0, rx_full_o)
    check_reg(`ADDR_DIV_INT, 8'h0A);
    check_reg(`ADDR_DIV_FRAC, 8'h00);
    read_reg(`ADDR_STATUS, rv);
    `CHK("status", 2'b00, {rv[2], rv[0]})
    write_reg(`ADDR_CTRL, 8'h18);
    repeat (2000) @(posedge ref_clk_i);
    read_reg(`ADDR_DATA, rv);
  endtask

  task automatic t_update_method();
    write_reg(`ADDR_CTRL, 8'h38);
    write_reg(`ADDR_DIV_INT, 8'h0C);
    check_reg(`ADDR_DIV_INT, 8'h0A);
    master.send_byte(8'h3C, 160);
    check_reg(`ADDR_DIV_INT, 8'h0C);
    check_reg(`ADDR_CTRL, 8'h18);
    check_reg(`ADDR_DATA, 8'h3C);
    write_reg(`ADDR_DIV_INT, 8'h0A);
  endtask

  task automatic t_mute_wake(input logic hdm);
    logic [7:0] ctl;
    ctl = 8'h19 | {6'h00, hdm, 1'b0};
    write_reg(`ADDR_CTRL, ctl);
    master.send_byte(8'h5A, 160);
    `CHK("full while muted", 1'b0, rx_full_o)
    master.send_break(160);
    if (hdm)
    begin
      check_reg(`ADDR_CTRL, ctl);
      master.send_byte(8'h55, 160);
      master.send_byte(8'h2A, 160);
      check_reg(`ADDR_DATA, 8'h2A);
    end
    check_reg(`ADDR_CTRL, ctl & 8'hFE);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    rst_i   = 1'b1;
    addr_i  = 3'h0;
    wdata_i = 8'h00;
    wr_i    = 1'b0;
    rd_i    = 1'b0;
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    @(posedge ref_clk_i);
    t_reset_values();
    t_div_write();
    t_master_rate();
    t_zero_char();
    t_auto_sync();
    t_update_method();
    t_mute_wake(1'b0);
    t_mute_wake(1'b1);
    close_out();
  end

  initial
  begin
    repeat (60000) @(posedge ref_clk_i);
    mismatches++;
    close_out();
  end
endmodule // tb
